//--- afmt_pkg.sv
/*
  constants, types and register map of the output formatter.
  assumes a 20 MHz system clock and a 32-bit AHB-Lite register bus.
*/
package afmt_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int NAP_PERIOD_NS = 2000;
  localparam int NAP_CYC = NAP_PERIOD_NS / CLK_PERIOD_NS;
  localparam int RELOCK_CYCLES = 100;
  localparam int PHASE_STEPS_LOG2 = 3;
  localparam logic [3:0] ADDR_TIMING = 4'h0;
  localparam logic [3:0] ADDR_OUTMODE = 4'h4;
  localparam logic [3:0] ADDR_FORMAT = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hc;
  localparam int TC_DCS = 0;
  localparam int TC_INV = 1;
  localparam int TC_PH = 2;
  localparam int OM_MODE = 0;
  localparam int OM_CUR = 2;
  localparam int OM_TERM = 5;
  localparam int DF_TWOS = 0;
  localparam int DF_RAND = 1;
  localparam int ST_NAP = 0;
  localparam int ST_LOCK = 1;
  localparam int ST_SE = 2;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [1:0] MODE_FULL = 2'h0;
  localparam logic [1:0] MODE_DDR_SE = 2'h1;
  localparam logic [1:0] MODE_DDR_DIFF = 2'h2;
  localparam logic [15:0] CODE_TOP = 16'hffff;
  localparam logic [15:0] CODE_BOTTOM = 16'h0000;
  localparam logic [15:0] MSB_FLIP = 16'h8000;
  localparam logic [12:0] CUR_DEFAULT_UA = 13'h0dac;
  // driver current per code, microamps; code 0 is the 3.5 mA default
  localparam logic [12:0] CUR_TABLE_UA [0:6] = '{
    13'h0dac, 13'h0fa0, 13'h1194, 13'h0bb8, 13'h09c4, 13'h0834, 13'h06d6
  };
  localparam logic [1:0] HRESP_OKAY = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {OM_FULL, OM_DDR_SE, OM_DDR_DIFF} afmt_mode_e;

  typedef struct packed {
    afmt_mode_e mode;
    logic dcs;
    logic inv;
    logic [1:0] phase;
    logic [2:0] cur;
    logic term;
    logic twos;
    logic rand_en;
  } afmt_cfg_s;
endpackage : afmt_pkg

//--- afmt_top.sv
/*
  output formatter: codes, saturates, randomizes and serializes converter
  samples onto full-rate or double-rate lanes with a forwarded clock.
  assumes core_code/core_over/core_under come from logic on mclk and are
  stable at each encode rising edge; encode pins and config straps are
  asynchronous and are synchronized here.
*/
// Added by the designer: the AHB-Lite register port and the address map.
// Notes on behaviour
// - three output modes, pin picks two in parallel
// - full rate: sixteen bits change on clock fall
// - double rate: two bits per lane, eight lanes
// - even bit while clock low, odd while high
// - differential: eight data, overrange and clock pairs
// - driver current default 3.5 mA, seven levels
// - internal termination doubles programmed driver current
// - overrange flag shares the sample pipeline latency
// - output clock delayed 0, 45, 90, 135 degrees, only with the stabilizer on and locked
// - separate bit inverts both output clock signals
// - offset binary default, two's complement selectable
// - midscale codes and saturation at extremes
// - randomize: upper bits xor least significant bit
// - stabilizer relocks over one hundred encode cycles
// - nap when encode stops or runs slow
// - grounded negative encode input selects single-ended
`timescale 1ns/1ps
`default_nettype none
module afmt_top
  import afmt_pkg::*;
#(
  parameter int CW = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic [1:0] hresp,
  input wire logic encode_in_pos,
  input wire logic encode_in_neg,
  input wire logic config_style_select,
  input wire logic par_ddr_diff_sel,
  input wire logic par_dcs_en,
  input wire logic [15:0] core_code,
  input wire logic core_over,
  input wire logic core_under,
  output logic [15:0] data_out,
  output logic [7:0] lane_neg,
  output logic overrange_flag,
  output logic overrange_flag_neg,
  output logic output_clock_pos,
  output logic output_clock_neg,
  output logic diff_drive_en,
  output logic term_en,
  output logic [13:0] drive_current_ua,
  output logic nap
);
  // synchronizers: pos, neg, style, ddr pin, dcs pin
  logic [4:0] sync1_q, sync2_q;
  always_ff @(posedge mclk) begin
    if (rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {par_dcs_en, par_ddr_diff_sel, config_style_select,
                  encode_in_neg, encode_in_pos};
      sync2_q <= sync1_q;
    end
  end

  // register bus
  logic [7:0] tc_q, tc_d, om_q, om_d, df_q, df_d;
  logic [3:0] wa_q, wa_d;
  logic wr_q, wr_d;
  logic [31:0] rd_q, rd_d;
  logic [7:0] status;
  logic [3:0] aoff;
  always_comb begin
    tc_d = tc_q;
    om_d = om_q;
    df_d = df_q;
    rd_d = rd_q;
    aoff = haddr[3:0];
    if (wr_q) begin
      unique case (wa_q)
        ADDR_TIMING: tc_d = hwdata[7:0];
        ADDR_OUTMODE: om_d = hwdata[7:0];
        ADDR_FORMAT: df_d = hwdata[7:0];
        default: ;
      endcase
    end
    wr_d = hready && hsel && htrans == HTRANS_NONSEQ && hwrite;
    wa_d = aoff;
    if (hready && hsel && htrans == HTRANS_NONSEQ && !hwrite) begin
      unique case (aoff)
        ADDR_TIMING: rd_d = {24'h00_0000, tc_q};
        ADDR_OUTMODE: rd_d = {24'h00_0000, om_q};
        ADDR_FORMAT: rd_d = {24'h00_0000, df_q};
        ADDR_STATUS: rd_d = {24'h00_0000, status};
        default: rd_d = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      tc_q <= REG_RST;
      om_q <= REG_RST;
      df_q <= REG_RST;
      wa_q <= 4'h0;
      wr_q <= 1'b0;
      rd_q <= 32'h0000_0000;
    end else begin
      tc_q <= tc_d;
      om_q <= om_d;
      df_q <= df_d;
      wa_q <= wa_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end
  assign hrdata = rd_q;

  // effective configuration; straps lock out double-rate single-ended
  afmt_cfg_s cfg;
  always_comb begin
    cfg = '0;
    if (sync2_q[2]) begin
      cfg.mode = sync2_q[3] ? OM_DDR_DIFF : OM_FULL;
      cfg.dcs = sync2_q[4];
    end else begin
      unique case (om_q[OM_MODE +: 2])
        MODE_DDR_SE: cfg.mode = OM_DDR_SE;
        MODE_DDR_DIFF: cfg.mode = OM_DDR_DIFF;
        default: cfg.mode = OM_FULL;
      endcase
      cfg.dcs = tc_q[TC_DCS];
      cfg.inv = tc_q[TC_INV];
      cfg.phase = tc_q[TC_PH +: 2];
      cfg.cur = om_q[OM_CUR +: 3];
      cfg.term = om_q[OM_TERM];
      cfg.twos = df_q[DF_TWOS];
      cfg.rand_en = df_q[DF_RAND];
    end
  end

  // encode timing: period, nap, stabilizer lock, single-ended detect
  logic enc_lvl, enc_prev_q, rise;
  logic [CW-1:0] cnt_q, cnt_d, per_q, per_d, negcnt_q, negcnt_d;
  logic [6:0] relock_q, relock_d;
  logic nap_q, nap_d, se_q, se_d;
  logic [CW-1:0] half;
  always_comb begin
    // single-ended when neg stays low over a nap window
    negcnt_d = sync2_q[1] ? '0 : negcnt_q;
    if (!sync2_q[1] && negcnt_q <= CW'(NAP_CYC))
      negcnt_d = negcnt_q + 1'b1;
    se_d = negcnt_q > CW'(NAP_CYC);
    enc_lvl = se_q ? sync2_q[0] : (sync2_q[0] && !sync2_q[1]);
    rise = enc_lvl && !enc_prev_q;
    half = per_q >> 1;
    cnt_d = cnt_q;
    per_d = per_q;
    relock_d = relock_q;
    nap_d = nap_q;
    if (rise) begin
      cnt_d = '0;
      per_d = cnt_q + 1'b1;
      nap_d = 1'b0;
      if (nap_q || per_d != per_q)
        relock_d = 7'(RELOCK_CYCLES);
      else if (relock_q != 7'h00)
        relock_d = relock_q - 1'b1;
    end else if (cnt_q < CW'(NAP_CYC)) begin
      cnt_d = cnt_q + 1'b1;
    end else begin
      nap_d = 1'b1;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      enc_prev_q <= 1'b0;
      cnt_q <= '0;
      per_q <= '0;
      negcnt_q <= '0;
      relock_q <= 7'h00;
      nap_q <= 1'b1;
      se_q <= 1'b0;
    end else begin
      enc_prev_q <= enc_lvl;
      cnt_q <= cnt_d;
      per_q <= per_d;
      negcnt_q <= negcnt_d;
      relock_q <= relock_d;
      nap_q <= nap_d;
      se_q <= se_d;
    end
  end
  assign status = {5'h00, se_q, relock_q == 7'h00, nap_q};

  // sample formatting, one word per encode rise
  logic [15:0] fmt, word_q, word_d;
  logic ovr_q, ovr_d;
  always_comb begin
    fmt = core_code;
    if (core_over)
      fmt = CODE_TOP;
    else if (core_under)
      fmt = CODE_BOTTOM;
    if (cfg.twos)
      fmt = fmt ^ MSB_FLIP;
    if (cfg.rand_en)
      fmt = fmt ^ {{15{fmt[0]}}, 1'b0};
    word_d = word_q;
    ovr_d = ovr_q;
    if (rise && !nap_q) begin
      word_d = fmt;
      ovr_d = core_over || core_under;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      word_q <= 16'h0000;
      ovr_q <= 1'b0;
    end else begin
      word_q <= word_d;
      ovr_q <= ovr_d;
    end
  end

  // pins: data changes on rise, and at half period in double rate; clock phase derived
  logic [15:0] data_q, data_d;
  logic [7:0] lneg_q, lneg_d, even, odd;
  logic of_q, of_d, ck_q, ck_d, base;
  logic [CW-1:0] dly, sp;
  logic [CW+1:0] prod;
  logic [13:0] cur_q, cur_d;
  logic [12:0] cur_ua;
  logic diff_q, term_q, nap_o_q, ofn_q, ckn_q;
  for (genvar g = 0; g < 8; g++) begin : g_lane
    assign even[g] = word_d[2*g];
    assign odd[g] = word_d[2*g+1];
  end
  always_comb begin
    // 45 degree steps are eighths of the measured encode period
    prod = (CW+2)'(cfg.phase) * (CW+2)'(per_q);
    dly = (cfg.dcs && relock_q == 7'h00) ?
          CW'(prod >> PHASE_STEPS_LOG2) : '0;
    // next count, so clock and lane edges land on the same mclk edge
    sp = (cnt_d >= dly) ? cnt_d - dly : cnt_d + per_q - dly;
    // without the stabilizer the clock follows the encode duty cycle
    base = cfg.dcs ? (sp >= half) : !enc_lvl;
    ck_d = base ^ cfg.inv;
    data_d = data_q;
    of_d = of_q;
    if (rise && !nap_q) begin
      of_d = ovr_d;
      if (cfg.mode == OM_FULL)
        data_d = word_d;
      else
        data_d = {8'h00, even};
    end else if (cnt_d == half && cfg.mode != OM_FULL && !nap_q) begin
      data_d = {8'h00, odd};
    end
    lneg_d = (cfg.mode == OM_DDR_DIFF) ? ~data_d[7:0] : 8'h00;
    cur_ua = (cfg.cur == 3'h7) ? CUR_DEFAULT_UA : CUR_TABLE_UA[cfg.cur];
    cur_d = cfg.term ? {cur_ua, 1'b0} : {1'b0, cur_ua};
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      data_q <= 16'h0000;
      lneg_q <= 8'h00;
      of_q <= 1'b0;
      ck_q <= 1'b0;
      ofn_q <= 1'b1;
      ckn_q <= 1'b1;
      cur_q <= {1'b0, CUR_DEFAULT_UA};
      diff_q <= 1'b0;
      term_q <= 1'b0;
      nap_o_q <= 1'b1;
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
    end else begin
      data_q <= data_d;
      lneg_q <= lneg_d;
      of_q <= of_d;
      ck_q <= ck_d;
      ofn_q <= !of_d;
      ckn_q <= !ck_d;
      cur_q <= cur_d;
      diff_q <= cfg.mode == OM_DDR_DIFF;
      term_q <= cfg.term && cfg.mode == OM_DDR_DIFF;
      nap_o_q <= nap_q;
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
    end
  end
  assign data_out = data_q;
  assign lane_neg = lneg_q;
  assign overrange_flag = of_q;
  // complements come from their own flops so both legs switch together
  assign overrange_flag_neg = ofn_q;
  assign output_clock_pos = ck_q;
  assign output_clock_neg = ckn_q;
  assign diff_drive_en = diff_q;
  assign term_en = term_q;
  assign drive_current_ua = cur_q;
  assign nap = nap_o_q;
endmodule : afmt_top
`default_nettype wire

//--- afmt_chk.sv
/* port assertions on the output formatter.
   assumes it is bound to afmt_top from the bench top. */
`timescale 1ns/1ps
`default_nettype none
module afmt_chk
  import afmt_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [1:0] hresp,
  input wire logic encode_in_pos,
  input wire logic [15:0] data_out,
  input wire logic [7:0] lane_neg,
  input wire logic overrange_flag,
  input wire logic overrange_flag_neg,
  input wire logic output_clock_pos,
  input wire logic output_clock_neg,
  input wire logic diff_drive_en,
  input wire logic [13:0] drive_current_ua,
  input wire logic nap
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic enc_q, enc_d;
  logic [5:0] idle_q, idle_d;
  // saturates, so a stopped encode clock never wraps the count
  always_comb begin
    enc_d = encode_in_pos;
    idle_d = (&idle_q) ? idle_q : idle_q + 6'h01;
    if (rst || encode_in_pos != enc_q) idle_d = 6'h00;
  end
  always_ff @(posedge mclk) begin
    enc_q <= enc_d;
    idle_q <= idle_d;
  end
  sequence s_napping;
    nap ##1 nap;
  endsequence
  a_nap_entry: assert property (idle_q == 6'h32 |-> nap)
    else $error("no nap");
  a_nap_freeze: assert property (s_napping |-> $stable(data_out))
    else $error("data moved in nap");
  a_clk_pair: assert property (output_clock_neg != output_clock_pos)
    else $error("clock pair");
  a_of_pair: assert property (overrange_flag_neg != overrange_flag)
    else $error("flag pair");
  a_lane_comp: assert property (diff_drive_en [*2] |->
    lane_neg == ~data_out[7:0]) else $error("lane pair");
  a_ddr_top: assert property ((diff_drive_en && !nap) [*8] |->
    data_out[15:8] == 8'h00) else $error("upper lines");
  a_cur_one: assert property (drive_current_ua inside
    {14'h06d6, 14'h0834, 14'h09c4, 14'h0bb8, 14'h0dac, 14'h0fa0, 14'h1194,
    14'h1068, 14'h1388, 14'h1770, 14'h1b58, 14'h1f40, 14'h2328})
    else $error("drive current");
  a_resp_ok: assert property (hresp == HRESP_OKAY)
    else $error("response");
endmodule : afmt_chk
`default_nettype wire

//--- afmt_rx.sv
/* receiving logic model: rebuilds words from the output lines.
   assumes each half of the output clock spans several mclk cycles. */
`timescale 1ns/1ps
`default_nettype none
module afmt_rx (
  input wire logic mclk,
  input wire logic [15:0] data_out,
  input wire logic overrange_flag,
  input wire logic output_clock_pos,
  input wire logic ddr,
  input wire logic rnd,
  output logic [16:0] word,
  output int count
);
  logic [16:0] d1, d2, lo;
  logic ck;
  initial count = 0;
  function automatic logic [16:0] rx(input logic [16:0] e, o);
    logic [15:0] v;
    for (int i = 0; i < 8; i++) begin
      v[2*i] = ddr ? e[i] : o[2*i];
      v[2*i+1] = ddr ? o[i] : o[2*i+1];
    end
    if (rnd) v[15:1] = v[15:1] ^ {15{v[0]}};
    return {o[16], v};
  endfunction : rx
  // looks two cycles back so a cycle of skew at an edge does no harm
  always @(posedge mclk) begin
    d1 <= {overrange_flag, data_out};
    d2 <= d1;
    ck <= output_clock_pos;
    if (output_clock_pos && !ck) lo <= d2;
    if (ddr ? ck && !output_clock_pos : output_clock_pos && !ck) begin
      word <= rx(lo, d2);
      count <= count + 1;
    end
  end
endmodule : afmt_rx
`default_nettype wire

//--- afmt_top_tb_top.sv
/* bench top: bus master, encode clock, core samples and checks.
   assumes afmt_chk and afmt_rx are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module afmt_top_tb_top
  import afmt_pkg::*;
;
  logic mclk = 0, rst = 1, hsel = 0, hwrite = 0, enc = 0, run = 1, se = 1;
  logic par = 0, psel = 0, pdcs = 0, over = 0, under = 0, hreadyout, of;
  logic ck_p, diff, nap, term;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd, rv = '0;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = '0;
  logic [15:0] code = '0, data_out;
  logic [16:0] word;
  logic [13:0] cur;
  int bad_count = 0, compares = 0, seed = 56584, m = 0, n, cnt;
  logic [13:0] ua [8] = '{14'h0dac, 14'h0fa0, 14'h1194, 14'h0bb8,
    14'h09c4, 14'h0834, 14'h06d6, 14'h0dac};
  always #25 mclk = ~mclk;
  always #200 enc = run ? ~enc : 1'b0;
  afmt_top dut_u (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
    .encode_in_pos(enc), .encode_in_neg(se ? 1'b0 : ~enc),
    .config_style_select(par), .par_ddr_diff_sel(psel), .par_dcs_en(pdcs),
    .core_code(code), .core_over(over), .core_under(under),
    .data_out(data_out), .lane_neg(), .overrange_flag(of),
    .overrange_flag_neg(), .output_clock_pos(ck_p), .output_clock_neg(),
    .diff_drive_en(diff), .term_en(term), .drive_current_ua(cur), .nap(nap));
  afmt_rx rx_u (.mclk(mclk), .data_out(data_out), .overrange_flag(of),
    .output_clock_pos(ck_p), .ddr(m inside {1, 2}), .rnd(rv[17]),
    .word(word), .count(cnt));
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= 32'(a);
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic chk(input logic [31:0] g, e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  function automatic logic [31:0] fmt(input logic [15:0] c, input logic o, u, t);
    logic [15:0] v;
    v = o ? 16'hffff : (u ? 16'h0000 : c);
    return {15'h0000, o | u, v ^ {t, 15'h0000}};
  endfunction : fmt
  task automatic conclude;
    $display("compares %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0; // encode at 2.5 Msps keeps the stabilizer legal
    @(posedge mclk);
    for (int a = 0; a < 3; a++) begin
      bus(1'b0, 4'(4 * a), '0);
      chk(rd, '0);
    end
    $display("test reset values done");
    for (int k = 0; k < 16; k++) begin
      n = 32'({k[3], k[2:0], 2'h2});
      bus(1'b1, ADDR_OUTMODE, n);
      bus(1'b0, ADDR_OUTMODE, '0);
      chk(rd, n);
      chk(cur, k[3] ? ua[k[2:0]] << 1 : ua[k[2:0]]);
      chk(term, k[3]);
    end
    $display("test drive current done");
    for (int i = 0; i < 32; i++) begin
      rv = $random(seed);
      m = i % 4;
      bus(1'b1, ADDR_OUTMODE, 32'(m));
      bus(1'b1, ADDR_FORMAT, 32'(rv[17:16]));
      code <= (i % 5 == 0) ? MSB_FLIP : rv[15:0];
      over <= (i % 5 == 1);
      under <= (i % 5 == 2);
      repeat (4) @(posedge enc);
      @(posedge mclk);
      chk(word, fmt(code, over, under, rv[16]));
    end
    $display("test data words done");
    @(posedge enc);
    @(posedge mclk);
    n = cnt;
    repeat (8) @(posedge enc);
    @(posedge mclk);
    chk(cnt - n, 32'h0000_0008);
    $display("test word rate done");
    run <= 1'b0;
    repeat (60) @(posedge mclk);
    chk(nap, 1'b1);
    bus(1'b0, ADDR_STATUS, '0);
    chk(rd[2], 1'b1);
    chk(rd[0], 1'b1);
    se <= 1'b0;
    run <= 1'b1;
    repeat (8) @(posedge enc);
    @(posedge mclk);
    bus(1'b1, ADDR_STATUS, 32'hffff_ffff);
    bus(1'b0, ADDR_STATUS, '0);
    chk(rd, '0);
    $display("test nap and encode done");
    par <= 1'b1;
    psel <= 1'b1;
    pdcs <= 1'b1;
    repeat (8) @(posedge mclk);
    chk({diff, cur}, 32'h0000_4dac);
    psel <= 1'b0;
    repeat (8) @(posedge mclk);
    chk(diff, 1'b0);
    $display("test parallel pins done");
    par <= 1'b0;
    bus(1'b1, ADDR_TIMING, 32'h0000_0001);
    repeat (100) @(posedge enc);
    for (int j = 0; j < 8; j++) begin
      bus(1'b1, ADDR_TIMING, 32'({j[2:1], j[0], 1'b1}));
      repeat (2) @(posedge enc);
      // one count after the encode rise: a shift of 90 degrees or more
      // keeps the clock high there
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      chk(ck_p, j[2] ^ j[0]);
      @(posedge mclk);
    end
    $display("test clock phase done");
    conclude();
  end
  initial begin
    #2000000;
    bad_count++;
    conclude();
  end
endmodule : afmt_top_tb_top
bind afmt_top afmt_chk chk_u (.mclk(mclk), .rst(rst), .hresp(hresp),
  .encode_in_pos(encode_in_pos), .data_out(data_out), .lane_neg(lane_neg),
  .overrange_flag(overrange_flag), .overrange_flag_neg(overrange_flag_neg),
  .output_clock_pos(output_clock_pos), .output_clock_neg(output_clock_neg),
  .diff_drive_en(diff_drive_en), .drive_current_ua(drive_current_ua),
  .nap(nap));
`default_nettype wire
